// File: rtl/sft_pkg.sv
// Constants and types shared by the serial frame transmitter
package sft_pkg;
  // Character size codes
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_6 = 3'h1;
  localparam logic [2:0] CSZ_7 = 3'h2;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;
  // Parity mode codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // Bit-clock prescale per mode (baud generator ticks per bit)
  localparam logic [4:0] DIV_NORMAL = 5'h10;
  localparam logic [4:0] DIV_DOUBLE = 5'h08;
  localparam logic [4:0] DIV_SYNC = 5'h02;
  // Baud divisor width
  localparam int BAUD_W = 12;
  // Reset values
  localparam logic LINE_IDLE = 1'h1;
  localparam logic [4:0] PRE_RESET = 5'h00;
  // Frame phase encoding
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP = 5'h10
  } tx_state_type;
endpackage : sft_pkg

// File: rtl/sft_bit_clock.sv
// Bit-rate tick generator for the transmitter
`timescale 1ns/1ps
`default_nettype none
module sft_bit_clock
  import sft_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Configuration
  input wire logic [BAUD_W-1:0] i_baud_divisor,
  input wire logic i_double_speed_bit,
  input wire logic i_sync_mode_select,
  input wire logic i_sync_slave,
  // External clock change edge (already synchronised and edge detected)
  input wire logic i_ext_edge,
  // Outputs
  output logic o_tick,
  output logic o_xck
);
  logic [BAUD_W-1:0] baud_cnt; // Baud generator down counter
  logic [4:0] pre_cnt; // Per-bit prescaler
  logic [4:0] div; // Selected prescale
  logic baud_tick; // One pulse per baud generator period

  // Prescale select: 16 normal, 8 double, 2 sync master
  always_comb begin
    if (i_sync_mode_select) begin
      div = DIV_SYNC;
    end else if (i_double_speed_bit) begin
      div = DIV_DOUBLE;
    end else begin
      div = DIV_NORMAL;
    end
  end

  assign baud_tick = (baud_cnt == '0);

  // Baud generator: reload with divisor at zero
  always_ff @(posedge i_clk) begin
    if (i_srst || baud_tick) begin
      baud_cnt <= i_baud_divisor;
    end else begin
      baud_cnt <= baud_cnt - BAUD_W'(1);
    end
  end

  // Prescaler counts baud ticks up to div
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pre_cnt <= PRE_RESET;
    end else if (baud_tick) begin
      pre_cnt <= (pre_cnt >= div - 5'h01) ? PRE_RESET : pre_cnt + 5'h01;
    end
  end

  // Bit tick: slave uses external edge, else prescaler wrap
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tick <= 1'b0;
    end else if (i_sync_mode_select && i_sync_slave) begin
      o_tick <= i_ext_edge;
    end else begin
      o_tick <= baud_tick && (pre_cnt >= div - 5'h01);
    end
  end

  // Master clock out: rises with the bit tick, so data changes on the rising side
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_xck <= 1'b0;
    end else begin
      o_xck <= (pre_cnt == PRE_RESET);
    end
  end
endmodule : sft_bit_clock
`default_nettype wire

// File: rtl/serial_frame_transmitter.sv
// Serial frame transmitter: buffer, shifter, parity and flags
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - All thirty frame formats are supported
// - Start bit, then data LSB first
// - Parity follows last data bit
// - Next frame directly, else line high
// - One shared format field set
// - Receiver checks only first stop bit
// - Even parity XOR, odd inverted
// - Size, parity, stop fields select format
// - Enable takes over serial output pin
// - Sync master mode takes over transfer clock
// - Data write loads buffer, starts send
// - Buffer moves to shifter without gap
// - Shifter sends at configured bit rate
// - Upper bits beyond size ignored
// - Prescale 16, 8 or 2 by mode
// - Empty flag set when free, cleared on write
// - Complete flag on finish, write-one clears
// - Disable waits until everything sent
module serial_frame_transmitter
  import sft_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Host data write
  input wire logic i_data_write,
  input wire logic [7:0] i_serial_data_register,
  input wire logic i_transmit_ninth_bit,
  // Shared frame format and enables
  input wire logic i_transmit_enable_bit,
  input wire logic [2:0] i_character_size_field,
  input wire logic [1:0] i_parity_mode_field,
  input wire logic i_stop_bit_select,
  // Clock configuration
  input wire logic [BAUD_W-1:0] i_baud_divisor,
  input wire logic i_double_speed_bit,
  input wire logic i_sync_mode_select,
  input wire logic i_sync_slave,
  input wire logic i_clock_polarity,
  // Complete flag clears
  input wire logic i_tx_complete_clear,
  // Transfer clock pin
  input wire logic i_transfer_clock_pin,
  output logic o_transfer_clock_pin,
  output logic o_transfer_clock_pin_oe_n,
  // Serial output pin
  output logic o_serial_out_pin,
  output logic o_serial_out_pin_oe_n,
  // Status
  output logic o_buffer_empty_flag,
  output logic o_tx_complete_flag
);
  tx_state_type state; // Frame phase
  logic [8:0] buf_data; // Transmit buffer, nine bits
  logic buf_full; // Buffer holds unsent data
  logic [8:0] shift; // Shift register
  logic [3:0] bit_cnt; // Bits left in current phase
  logic [3:0] nbits; // Data bits for current format
  logic parity_acc; // Running parity of sent data
  logic owning; // Transmitter owns the pins
  logic tick; // Bit-rate tick
  logic xck_int; // Internal master clock
  logic xck_s1, xck_s2, xck_s3; // Sync and edge detect of external clock
  logic ext_edge; // Change edge of external clock
  logic load; // Buffer moves into shifter this cycle
  logic frame_end; // Last stop bit finishes this cycle

  // Format fields are read live by the start, data and parity phases; one set serves the whole unit
  // Size code to data bit count; reserved codes fall back to eight
  always_comb begin
    case (i_character_size_field)
      CSZ_5: nbits = 4'h5;
      CSZ_6: nbits = 4'h6;
      CSZ_7: nbits = 4'h7;
      CSZ_9: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end

  // External clock synchroniser; stages two and three feed the edge detector
  // No reset: the chain follows the pin level during a reset of three clocks or
  // more, so no false change edge appears when reset is released
  always_ff @(posedge i_clk) begin
    xck_s1 <= i_transfer_clock_pin;
    xck_s2 <= xck_s1;
    xck_s3 <= xck_s2;
  end

  // Change edge: rising when polarity is zero, falling otherwise
  assign ext_edge = i_clock_polarity ? (xck_s3 && !xck_s2) : (!xck_s3 && xck_s2);

  // Bit-rate generator
  sft_bit_clock u_bit_clock (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_baud_divisor(i_baud_divisor),
    .i_double_speed_bit(i_double_speed_bit),
    .i_sync_mode_select(i_sync_mode_select),
    .i_sync_slave(i_sync_slave),
    .i_ext_edge(ext_edge),
    .o_tick(tick),
    .o_xck(xck_int)
  );

  // Frame end and shifter load points; no idle bit between frames
  assign frame_end = tick && (state == ST_STOP) && (bit_cnt == 4'h1);
  // Loading only on a tick keeps a pending byte in the buffer until the shifter takes it
  assign load = buf_full && ((state == ST_IDLE && tick) || frame_end);

  // Transmit buffer: write fills, load drains; write wins on same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      buf_full <= 1'b0;
      buf_data <= 9'h000;
    end else if (i_data_write) begin
      // A write on a load cycle refills the buffer while the old byte moves on
      buf_full <= 1'b1;
      buf_data <= {i_transmit_ninth_bit, i_serial_data_register};
    end else if (load) begin
      buf_full <= 1'b0;
    end
  end

  // Frame sequencer: start, data LSB first, parity, stops
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      shift <= 9'h000;
      bit_cnt <= 4'h0;
      parity_acc <= 1'b0;
    end else if (load) begin
      state <= ST_START;
      shift <= buf_data;
      bit_cnt <= 4'h1;
      parity_acc <= 1'b0;
    end else if (tick) begin
      case (state)
        ST_START: begin
          state <= ST_DATA;
          bit_cnt <= nbits;
        end
        ST_DATA: begin
          // Bits beyond the size never reach the line
          parity_acc <= parity_acc ^ shift[0];
          shift <= {1'b0, shift[8:1]};
          if (bit_cnt == 4'h1) begin
            state <= (i_parity_mode_field[1]) ? ST_PARITY : ST_STOP;
            bit_cnt <= i_parity_mode_field[1] ? 4'h1 : (i_stop_bit_select ? 4'h2 : 4'h1);
          end else begin
            bit_cnt <= bit_cnt - 4'h1;
          end
        end
        ST_PARITY: begin
          state <= ST_STOP;
          bit_cnt <= i_stop_bit_select ? 4'h2 : 4'h1;
        end
        ST_STOP: begin
          // A receiver judges only the first stop bit; a second one is plain high
          if (bit_cnt == 4'h1) begin
            state <= ST_IDLE;
          end
          bit_cnt <= bit_cnt - 4'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Serial line value per phase; idle high
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_serial_out_pin <= LINE_IDLE;
    end else begin
      case (state)
        ST_START: o_serial_out_pin <= 1'b0;
        ST_DATA: o_serial_out_pin <= shift[0];
        ST_PARITY: o_serial_out_pin <= parity_acc ^ i_parity_mode_field[0];
        default: o_serial_out_pin <= LINE_IDLE;
      endcase
    end
  end

  // Pin ownership held until shifter and buffer drain
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      owning <= 1'b0;
    end else if (i_transmit_enable_bit) begin
      owning <= 1'b1;
    end else if (state == ST_IDLE && !buf_full && !i_data_write) begin
      owning <= 1'b0;
    end
  end

  // Output enables (low drives) and master clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_serial_out_pin_oe_n <= 1'b1;
      o_transfer_clock_pin_oe_n <= 1'b1;
      o_transfer_clock_pin <= 1'b0;
    end else begin
      o_serial_out_pin_oe_n <= !owning;
      o_transfer_clock_pin_oe_n <= !(owning && i_sync_mode_select && !i_sync_slave);
      o_transfer_clock_pin <= xck_int ^ i_clock_polarity;
    end
  end

  // Buffer-empty flag mirrors buffer state; write clears
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_buffer_empty_flag <= 1'b1;
    end else begin
      o_buffer_empty_flag <= !(i_data_write || (buf_full && !load));
    end
  end

  // Complete flag: set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_complete_flag <= 1'b0;
    end else if (frame_end && !buf_full) begin
      o_tx_complete_flag <= 1'b1;
    end else if (i_tx_complete_clear) begin
      o_tx_complete_flag <= 1'b0;
    end
  end

  // Assertions
  a_start_low: assert property (@(posedge i_clk) disable iff (i_srst)
    state == ST_START |=> o_serial_out_pin == 1'b0)
    else $error("start bit not low");
  a_idle_high: assert property (@(posedge i_clk) disable iff (i_srst)
    state == ST_IDLE |=> o_serial_out_pin == 1'b1)
    else $error("idle line not high");
  a_start_to_data: assert property (@(posedge i_clk) disable iff (i_srst)
    (state == ST_START && tick) |=> state == ST_DATA && bit_cnt == nbits)
    else $error("data phase wrong after start");
  a_parity_next: assert property (@(posedge i_clk) disable iff (i_srst)
    (state == ST_DATA && tick && bit_cnt == 4'h1 && i_parity_mode_field[1]) |=>
    state == ST_PARITY)
    else $error("parity not after data");
  a_parity_value: assert property (@(posedge i_clk) disable iff (i_srst)
    state == ST_PARITY |=> o_serial_out_pin == ($past(parity_acc) ^ $past(i_parity_mode_field[0])))
    else $error("parity bit wrong");
  a_write_clears_empty: assert property (@(posedge i_clk) disable iff (i_srst)
    i_data_write |=> !o_buffer_empty_flag)
    else $error("empty flag not cleared");
  a_complete_set: assert property (@(posedge i_clk) disable iff (i_srst)
    (frame_end && !buf_full) |=> o_tx_complete_flag)
    else $error("complete flag not set");
  a_drive_enabled: assert property (@(posedge i_clk) disable iff (i_srst)
    i_transmit_enable_bit |=> ##1 !o_serial_out_pin_oe_n)
    else $error("pin not driven");
  a_hold_busy: assert property (@(posedge i_clk) disable iff (i_srst)
    (state != ST_IDLE) |=> ##1 !o_serial_out_pin_oe_n || !$past(owning, 2))
    else $error("pin released mid frame");
  a_back_to_back: assert property (@(posedge i_clk) disable iff (i_srst)
    (frame_end && buf_full) |=> state == ST_START)
    else $error("gap between frames");
  // Pending byte is never dropped while the shifter waits for a tick
  a_pending_kept: assert property (@(posedge i_clk) disable iff (i_srst)
    (state == ST_IDLE && buf_full && !tick) |=> state == ST_IDLE && buf_full)
    else $error("pending byte lost");
  // Stop bits are high whatever the format
  a_stop_high: assert property (@(posedge i_clk) disable iff (i_srst)
    state == ST_STOP |=> o_serial_out_pin == 1'b1)
    else $error("stop bit not high");
  a_stop_count: assert property (@(posedge i_clk) disable iff (i_srst)
    (state == ST_PARITY && tick) |=> bit_cnt == (i_stop_bit_select ? 4'h2 : 4'h1))
    else $error("stop count wrong");
  // Flags
  a_empty_on_load: assert property (@(posedge i_clk) disable iff (i_srst)
    (load && !i_data_write) |=> o_buffer_empty_flag)
    else $error("empty flag not set");
  a_complete_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_tx_complete_clear && !(frame_end && !buf_full)) |=> !o_tx_complete_flag)
    else $error("complete flag not cleared");
  // Pins
  a_clock_owned: assert property (@(posedge i_clk) disable iff (i_srst)
    (owning && i_sync_mode_select && !i_sync_slave) |=> !o_transfer_clock_pin_oe_n)
    else $error("clock pin not driven");
  a_released_idle: assert property (@(posedge i_clk) disable iff (i_srst)
    (!i_transmit_enable_bit && state == ST_IDLE && !buf_full && !i_data_write) |=>
    ##1 o_serial_out_pin_oe_n)
    else $error("pin not released");
  // Scenarios the bench should reach
  c_frame_done: cover property (@(posedge i_clk) frame_end);
  c_sync_master: cover property (@(posedge i_clk) !o_transfer_clock_pin_oe_n && tick);
  c_parity_sent: cover property (@(posedge i_clk) state == ST_PARITY);
  c_back_to_back: cover property (@(posedge i_clk) frame_end && buf_full);
  c_two_stops: cover property (@(posedge i_clk) state == ST_STOP && bit_cnt == 4'h2);
endmodule : serial_frame_transmitter
`default_nettype wire

// File: dv/serial_peer_model.sv
// Receiving peer that decodes frames seen on the serial line
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
  // Clock and line
  input wire logic i_clk,
  input wire logic i_line,
  // Format the peer expects
  input var int i_bits,
  input wire logic i_par_en,
  input var int i_period,
  // Last frame seen
  output logic [8:0] o_data,
  output logic o_par,
  output logic o_ferr,
  output int o_count
);
  logic [8:0] d; // Bits being gathered
  int cnt = 0; // Frames decoded so far
  assign o_count = cnt;
  // One start edge, then mid-bit samples; sampling on the falling edge avoids races
  always begin
    @(negedge i_line);
    repeat (i_period / 2) @(negedge i_clk);
    d = 9'h000;
    for (int k = 0; k < i_bits; k++) begin
      repeat (i_period) @(negedge i_clk);
      d[k] = i_line; // Lowest bit first
    end
    o_par = 1'b0;
    if (i_par_en) begin
      repeat (i_period) @(negedge i_clk);
      o_par = i_line; // Right after the last data bit
    end
    repeat (i_period) @(negedge i_clk);
    o_ferr = ~i_line; // Only the first stop bit is judged
    o_data = d;
    cnt = cnt + 1;
  end
endmodule : serial_peer_model
`default_nettype wire

// File: dv/serial_frame_transmitter_tb.sv
// Self-checking bench for the serial frame transmitter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module serial_frame_transmitter_tb import sft_pkg::*; ;
  // Stimulus, one shared format set
  logic i_clk = 0, i_srst = 1, i_data_write = 0, i_transmit_ninth_bit = 0;
  logic [7:0] i_serial_data_register = 8'h00;
  logic i_transmit_enable_bit = 0, i_stop_bit_select = 0, i_double_speed_bit = 0;
  logic i_sync_mode_select = 0, i_tx_complete_clear = 0, i_sync_slave = 0;
  logic xck_in = 0, xck_run = 0; // Slave clock the bench makes, running through the whole slave rate step, idle gaps included
  logic [2:0] i_character_size_field = CSZ_8;
  logic [1:0] i_parity_mode_field = PAR_NONE;
  logic [BAUD_W-1:0] i_baud_divisor = 12'h001;
  // Design outputs and the resolved line
  logic o_transfer_clock_pin, o_transfer_clock_pin_oe_n, o_serial_out_pin;
  logic o_serial_out_pin_oe_n, o_buffer_empty_flag, o_tx_complete_flag, line;
  // Peer results and bench state
  logic [8:0] rx_data;
  logic rx_par, rx_ferr;
  int rx_count, nbits = 8, period = 32, n_mismatch = 0, samples_checked = 0;
  always #2.5 i_clk = ~i_clk;
  // Slave clock: one change edge every eight clocks while xck_run is set for the whole slave rate step
  always begin
    repeat (4) @(negedge i_clk);
    if (xck_run) xck_in = ~xck_in;
  end
  // Pull-up holds the pin high once released
  assign line = o_serial_out_pin_oe_n ? 1'b1 : o_serial_out_pin;
  // Clock polarity stays at zero; master and slave clocking are both exercised
  serial_frame_transmitter dut (.i_clk(i_clk), .i_srst(i_srst), .i_data_write(i_data_write),
    .i_serial_data_register(i_serial_data_register), .i_transmit_ninth_bit(i_transmit_ninth_bit),
    .i_transmit_enable_bit(i_transmit_enable_bit), .i_character_size_field(i_character_size_field),
    .i_parity_mode_field(i_parity_mode_field), .i_stop_bit_select(i_stop_bit_select),
    .i_baud_divisor(i_baud_divisor), .i_double_speed_bit(i_double_speed_bit),
    .i_sync_mode_select(i_sync_mode_select), .i_sync_slave(i_sync_slave),
    .i_clock_polarity(1'b0),
    .i_tx_complete_clear(i_tx_complete_clear), .i_transfer_clock_pin(xck_in),
    .o_transfer_clock_pin(o_transfer_clock_pin),
    .o_transfer_clock_pin_oe_n(o_transfer_clock_pin_oe_n), .o_serial_out_pin(o_serial_out_pin),
    .o_serial_out_pin_oe_n(o_serial_out_pin_oe_n), .o_buffer_empty_flag(o_buffer_empty_flag),
    .o_tx_complete_flag(o_tx_complete_flag));
  serial_peer_model peer (.i_clk(i_clk), .i_line(line), .i_bits(nbits),
    .i_par_en(i_parity_mode_field[1]), .i_period(period), .o_data(rx_data), .o_par(rx_par),
    .o_ferr(rx_ferr), .o_count(rx_count));
  // Host write: waits for a free buffer, ninth bit goes with the byte
  task automatic wr(input logic [8:0] v);
    int n = 0;
    @(negedge i_clk);
    while (o_buffer_empty_flag !== 1'b1 && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_buffer_empty_flag, 1'b1)
    i_transmit_ninth_bit = v[8];
    i_serial_data_register = v[7:0];
    i_data_write = 1;
    @(negedge i_clk);
    i_data_write = 0;
  endtask : wr
  // Waits for frame c+1 at the peer, judges it, then clears the complete flag
  task automatic fin(input logic [8:0] d, input logic p, input int c);
    int n = 0;
    while (rx_count <= c && n < 9000) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(rx_count, c + 1)
    `CHK(rx_data, d)
    if (i_parity_mode_field[1]) `CHK(rx_par, p)
    `CHK(rx_ferr, 1'b0)
    n = 0;
    while (o_tx_complete_flag !== 1'b1 && n < 500) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_tx_complete_flag, 1'b1)
    i_tx_complete_clear = 1;
    @(negedge i_clk);
    i_tx_complete_clear = 0;
    `CHK(o_tx_complete_flag, 1'b0)
  endtask : fin
  // One frame; low > 0 also times the low span of start plus zero data
  task automatic xfer(input logic [8:0] v, input logic [8:0] d, input logic p, input int low);
    int c0, n = 0;
    c0 = rx_count;
    wr(v);
    if (low > 0) begin
      while (line !== 1'b0) @(negedge i_clk);
      if (!o_transfer_clock_pin_oe_n) `CHK(o_transfer_clock_pin, 1'b1)
      while (line === 1'b0) begin
        @(negedge i_clk);
        n++;
      end
      `CHK(n, low)
    end
    fin(d, p, c0);
  endtask : xfer
  // Reset values and pin takeover
  task automatic t_reset;
    repeat (10) @(negedge i_clk);
    `CHK(o_serial_out_pin, 1'b1)
    `CHK(o_serial_out_pin_oe_n, 1'b1)
    `CHK(o_buffer_empty_flag, 1'b1)
    `CHK(o_tx_complete_flag, 1'b0)
    // Mode, rate and format stand before enable; no interrupt source to mask
    i_srst = 0;
    i_transmit_enable_bit = 1;
    repeat (3) @(negedge i_clk);
    `CHK(o_serial_out_pin_oe_n, 1'b0)
    $display("test reset done");
  endtask : t_reset
  // All thirty formats; data with upper bits that must not leak
  task automatic t_formats;
    logic [2:0] sz [5] = '{CSZ_5, CSZ_6, CSZ_7, CSZ_8, CSZ_9};
    logic [1:0] pm [3] = '{PAR_NONE, PAR_EVEN, PAR_ODD};
    logic [8:0] m;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 6; j++) begin
        nbits = (i < 4) ? i + 5 : 9;
        m = 9'h1ff >> (9 - nbits);
        // Format changes only while idle
        i_character_size_field = sz[i];
        i_parity_mode_field = pm[j / 2];
        i_stop_bit_select = j[0];
        xfer(9'h15a, 9'h15a & m, ^(9'h15a & m) ^ pm[j / 2][0], 0);
      end
    end
    nbits = 8;
    i_character_size_field = CSZ_8;
    i_parity_mode_field = PAR_NONE;
    i_stop_bit_select = 0;
    $display("test formats done");
  endtask : t_formats
  // Bit period in normal, double speed, master and slave synchronous modes
  task automatic t_rates;
    int per [4] = '{32, 24, 8, 8};
    for (int k = 0; k < 4; k++) begin
      i_baud_divisor = BAUD_W'(k + 1);
      i_double_speed_bit = (k == 1);
      i_sync_mode_select = (k >= 2);
      i_sync_slave = (k == 3);
      xck_run = (k == 3);
      period = per[k];
      repeat (3) @(negedge i_clk);
      `CHK(o_transfer_clock_pin_oe_n, logic'(k != 2))
      xfer(9'h100, 9'h000, 1'b0, 9 * per[k]);
    end
    i_baud_divisor = 12'h001;
    i_double_speed_bit = 0;
    i_sync_mode_select = 0;
    i_sync_slave = 0;
    xck_run = 0;
    period = 32;
    $display("test rates done");
  endtask : t_rates
  // Second byte written during a frame follows with no gap
  task automatic t_b2b;
    int c0, n = 0;
    c0 = rx_count;
    wr(9'h000);
    while (line !== 1'b0) @(negedge i_clk);
    fork
      begin
        wr(9'h0ff);
        @(negedge i_clk);
        `CHK(o_buffer_empty_flag, 1'b0)
      end
    join_none
    while (line === 1'b0) begin
      @(negedge i_clk);
      n++;
    end
    while (line === 1'b1) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(n, 10 * period)
    `CHK(o_tx_complete_flag, 1'b0)
    fin(9'h0ff, 1'b0, c0 + 1);
    $display("test back_to_back done");
  endtask : t_b2b
  // Dropping enable lets the pending frame finish before release
  task automatic t_disable;
    int c0;
    c0 = rx_count;
    wr(9'h0a5);
    i_transmit_enable_bit = 0;
    repeat (40) @(negedge i_clk);
    `CHK(o_serial_out_pin_oe_n, 1'b0)
    fin(9'h0a5, 1'b0, c0);
    repeat (3) @(negedge i_clk);
    `CHK(o_serial_out_pin_oe_n, 1'b1)
    i_transmit_enable_bit = 1;
    repeat (3) @(negedge i_clk);
    `CHK(o_serial_out_pin_oe_n, 1'b0)
    $display("test disable done");
  endtask : t_disable
  // Reset in mid-frame returns pins and flags to rest, then enable takes over again
  task automatic t_midrst;
    wr(9'h033);
    while (line !== 1'b0) @(negedge i_clk);
    i_srst = 1;
    repeat (2) @(negedge i_clk);
    `CHK(o_serial_out_pin_oe_n, 1'b1)
    `CHK(o_buffer_empty_flag, 1'b1)
    `CHK(o_tx_complete_flag, 1'b0)
    i_srst = 0;
    repeat (400) @(negedge i_clk);
    `CHK(o_serial_out_pin_oe_n, 1'b0)
    `CHK(line, 1'b1)
    $display("test mid_reset done");
  endtask : t_midrst
  // Counts and verdict, then end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    t_reset;
    t_formats;
    t_rates;
    t_b2b;
    t_disable;
    t_midrst;
    stop_test;
  end
  // Watchdog well beyond the expected run of about 13k cycles
  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    stop_test;
  end
endmodule : serial_frame_transmitter_tb
`default_nettype wire
